// ===== sbcm_top.sv
// sbcm_top.sv: dual channel brake gating and feedback monitor
`default_nettype none
module sbcm_top #(
  parameter longint unsigned DISC_CYC = sbcm_pkg::DISC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic safety_input_a,
  input wire logic safety_input_b,
  input wire logic cpu_brake_open_request,
  input wire logic input_fail_det,
  input wire logic output_fail_det,
  output logic brake_power_out_a,
  output logic brake_power_out_b,
  output logic safety_feedback_out,
  output logic locked_open,
  output var sbcm_pkg::sbcm_state_t mon_state
);
  import sbcm_pkg::*;

  // ****************************************
  // input synchronisation
  // ****************************************
  logic [3:0] raw_in;
  logic [3:0] sync_in;
  sbcm_pair_t safe_in;
  sbcm_diag_t diag;
  logic cmd;
  assign raw_in = {safety_input_a, safety_input_b,
                   input_fail_det, output_fail_det};
  sbcm_sync #(.WIDTH(4)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(raw_in),
    .sync_out(sync_in)
  );
  assign safe_in = sync_in[3:2];
  assign diag = sync_in[1:0];
  assign cmd = cpu_brake_open_request;

  // ****************************************
  // brake channels
  // ****************************************
  logic safe_switch_channel_a;
  logic safe_switch_channel_b;
  logic both_high;
  logic both_low;
  logic disagree;
  assign safe_switch_channel_a = safe_in.in_a; // see (RULE3)
  assign safe_switch_channel_b = safe_in.in_b; // see (RULE3)
  assign both_high = safe_in.in_a & safe_in.in_b;
  assign both_low = ~safe_in.in_a & ~safe_in.in_b;
  assign disagree = safe_in.in_a ^ safe_in.in_b;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      brake_power_out_a <= 1'b0;
      brake_power_out_b <= 1'b0;
    end else begin
      // functional command only passes with both high; see (RULE2) (RULE5)
      brake_power_out_a <= safe_switch_channel_a & both_high
                           & cmd; // see (RULE1) (RULE3)
      brake_power_out_b <= safe_switch_channel_b & both_high
                           & cmd; // see (RULE1) (RULE3)
    end
  end

  // ****************************************
  // discrepancy timer
  // ****************************************
  logic [31:0] disc_cnt_q;
  logic disc_expired;
  assign disc_expired = (64'(disc_cnt_q) >= DISC_CYC);
  always_ff @(posedge ref_clk) begin
    if (rst || !disagree) begin
      disc_cnt_q <= '0; // see (RULE15)
    end else if (!disc_expired) begin
      disc_cnt_q <= disc_cnt_q + 32'h00000001; // see (RULE15)
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      locked_open <= LOCK_RESET;
    end else if (disc_expired && disagree) begin
      locked_open <= 1'b1; // see (RULE9)
    end else if (both_low) begin
      locked_open <= 1'b0; // see (RULE10)
    end
  end

  // ****************************************
  // feedback
  // ****************************************
  logic fb_d;
  always_comb begin
    if (diag.input_fail) begin
      fb_d = 1'b0; // see (RULE12)
    end else if (locked_open) begin
      fb_d = 1'b0; // see (RULE10)
    end else if (diag.output_fail && both_low) begin
      fb_d = 1'b1; // see (RULE11) (RULE8)
    end else begin
      // closed only with both outputs powered; see (RULE6) (RULE7)
      fb_d = brake_power_out_a & brake_power_out_b;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      safety_feedback_out <= 1'b0;
    end else begin
      safety_feedback_out <= fb_d;
    end
  end

  // ****************************************
  // state summary
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mon_state <= SBCM_SAFE;
    end else begin
      case (1'b1)
        (locked_open && !both_low): mon_state <= SBCM_LOCKED;
        both_high: mon_state <= SBCM_RELEASED;
        disagree: mon_state <= SBCM_HALF;
        default: mon_state <= SBCM_SAFE;
      endcase
    end
  end

  // ****************************************
  // intervention time watch
  // ****************************************
  // cycles a low input leaves its brake powered
  logic [31:0] off_wait_a_q;
  logic [31:0] off_wait_b_q;
  always_ff @(posedge ref_clk) begin
    if (rst || safe_in.in_a || !brake_power_out_a) begin
      off_wait_a_q <= '0;
    end else begin
      off_wait_a_q <= off_wait_a_q + 32'h00000001; // see (RULE13)
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst || safe_in.in_b || !brake_power_out_b) begin
      off_wait_b_q <= '0;
    end else begin
      off_wait_b_q <= off_wait_b_q + 32'h00000001; // see (RULE13)
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_low_in_off: assert property ( // see (RULE3)
    @(posedge ref_clk) disable iff (rst)
    !safe_in.in_a |=> !brake_power_out_a)
    else $error("channel a powered with input a low");
  a_b_low_off: assert property ( // see (RULE3)
    @(posedge ref_clk) disable iff (rst)
    !safe_in.in_b |=> !brake_power_out_b)
    else $error("channel b powered with input b low");
  a_half_off: assert property ( // see (RULE3)
    @(posedge ref_clk) disable iff (rst)
    disagree |=> !brake_power_out_a && !brake_power_out_b)
    else $error("brake powered with one input low");
  a_both_low_off: assert property ( // see (RULE1)
    @(posedge ref_clk) disable iff (rst)
    both_low |=> !brake_power_out_a && !brake_power_out_b)
    else $error("brake powered with both inputs low");
  a_no_cmd_off: assert property ( // see (RULE5)
    @(posedge ref_clk) disable iff (rst)
    !cmd |=> !brake_power_out_a && !brake_power_out_b)
    else $error("brake powered without command");
  a_release_on: assert property ( // see (RULE2)
    @(posedge ref_clk) disable iff (rst)
    both_high && cmd |=> brake_power_out_a && brake_power_out_b)
    else $error("brake not powered when released and commanded");
  a_drop_time: assert property ( // see (RULE13)
    @(posedge ref_clk) disable iff (rst)
    $fell(safety_input_a) |-> ##[1:4] !brake_power_out_a)
    else $error("brake a power not removed in time");
  a_drop_time_b: assert property ( // see (RULE13)
    @(posedge ref_clk) disable iff (rst)
    $fell(safety_input_b) |-> ##[1:4] !brake_power_out_b)
    else $error("brake b power not removed in time");
  a_drop_bound_a: assert property ( // see (RULE13)
    @(posedge ref_clk) disable iff (rst)
    64'(off_wait_a_q) < INTERV_CYCLES)
    else $error("brake a powered past intervention time");
  a_drop_bound_b: assert property ( // see (RULE13)
    @(posedge ref_clk) disable iff (rst)
    64'(off_wait_b_q) < INTERV_CYCLES)
    else $error("brake b powered past intervention time");
  a_fb_open: assert property ( // see (RULE6)
    @(posedge ref_clk) disable iff (rst)
    !brake_power_out_a && !brake_power_out_b && !diag.output_fail
    |=> !safety_feedback_out)
    else $error("feedback closed with outputs off");
  a_fb_closed: assert property ( // see (RULE7)
    @(posedge ref_clk) disable iff (rst)
    brake_power_out_a && brake_power_out_b && !locked_open
    && !diag.input_fail |=> safety_feedback_out)
    else $error("feedback open with outputs on");
  a_in_fail: assert property ( // see (RULE12)
    @(posedge ref_clk) disable iff (rst)
    diag.input_fail |=> !safety_feedback_out)
    else $error("feedback closed during input failure");
  a_lock_set: assert property ( // see (RULE9)
    @(posedge ref_clk) disable iff (rst)
    disagree && disc_expired |=> locked_open)
    else $error("lock not set on discrepancy expiry");
  a_lock_state: assert property ( // see (RULE9)
    @(posedge ref_clk) disable iff (rst)
    locked_open && !both_low |=> mon_state == SBCM_LOCKED)
    else $error("summary not locked while lock held");
  a_state_half: assert property ( // see (RULE3)
    @(posedge ref_clk) disable iff (rst)
    disagree && !locked_open |=> mon_state == SBCM_HALF)
    else $error("summary not half with one input high");
  a_lock_hold: assert property ( // see (RULE10)
    @(posedge ref_clk) disable iff (rst)
    locked_open |=> !safety_feedback_out)
    else $error("feedback closed while locked open");
  a_lock_keep: assert property ( // see (RULE10)
    @(posedge ref_clk) disable iff (rst)
    locked_open && !both_low |=> locked_open)
    else $error("lock dropped without both inputs low");
  a_lock_clear: assert property ( // see (RULE10)
    @(posedge ref_clk) disable iff (rst)
    locked_open && both_low |=> !locked_open)
    else $error("lock kept with both inputs low");
  a_out_fail: assert property ( // see (RULE11)
    @(posedge ref_clk) disable iff (rst)
    diag.output_fail && both_low && !diag.input_fail && !locked_open
    |=> safety_feedback_out)
    else $error("feedback not closed on output failure");
  a_timer_rst: assert property ( // see (RULE15)
    @(posedge ref_clk) disable iff (rst)
    !disagree |=> disc_cnt_q == 32'h00000000)
    else $error("discrepancy timer not restarted");
  a_timer_step: assert property ( // see (RULE15)
    @(posedge ref_clk) disable iff (rst)
    disagree && !disc_expired
    |=> disc_cnt_q == $past(disc_cnt_q) + 32'h00000001)
    else $error("discrepancy timer not counting");
endmodule : sbcm_top
`default_nettype wire

// ===== sbcm_pkg.sv
// sbcm_pkg.sv: constants and types of the safe brake channel monitor
// How it works
// (RULE1) both safety inputs low or open: both brake outputs unpowered.
// (RULE2) brake outputs follow the cpu command only with both inputs high.
// (RULE3) each low input forces its own brake output off on its own.
// (RULE4) the safety chain switches both inputs together, up and down.
// (RULE5) after release, outputs stay unpowered until the cpu requests open.
// (RULE6) feedback open while both channels are off and unpowered.
// (RULE7) feedback closed only with both outputs powered by the command.
// (RULE8) feedback disagreeing with inputs and outputs is an alarm to watch.
// (RULE9) one input high, other low beyond 2 s: feedback latches locked open.
// (RULE10) locked open holds feedback open; clears when both inputs go low.
// (RULE11) dangerous output section failure closes feedback with inputs low.
// (RULE12) input section failure keeps feedback open in every combination.
// (RULE13) brake power removed within 50 ms of the safety inputs dropping.
// (RULE14) the controller watches feedback against the expected state.
// (RULE15) discrepancy timer counts while inputs disagree, restarts on agree.
`default_nettype none
package sbcm_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned DISC_TIME_MS = 2000;
  localparam int unsigned INTERV_TIME_MS = 50;
  localparam longint unsigned DISC_CYCLES =
    longint'(CLK_HZ) / 1000 * DISC_TIME_MS;
  localparam longint unsigned INTERV_CYCLES =
    longint'(CLK_HZ) / 1000 * INTERV_TIME_MS;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic LOCK_RESET = 1'b0;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic in_a;
    logic in_b;
  } sbcm_pair_t;
  typedef struct packed {
    logic input_fail;
    logic output_fail;
  } sbcm_diag_t;
  typedef enum logic [1:0] {
    SBCM_SAFE = 2'b00,
    SBCM_HALF = 2'b01,
    SBCM_RELEASED = 2'b10,
    SBCM_LOCKED = 2'b11
  } sbcm_state_t;
endpackage : sbcm_pkg
`default_nettype wire

// ===== sbcm_sync.sv
// sbcm_sync.sv: two-stage synchroniser for a vector of pin levels
`default_nettype none
module sbcm_sync #(
  parameter int unsigned WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : sbcm_sync
`default_nettype wire

// ===== sbcm_chain_model.sv
// sbcm_chain_model.sv: safety chain and controller model
`default_nettype none
module sbcm_chain_model (
  input wire logic ref_clk,
  input wire logic chain_closed,
  input wire logic break_a,
  input wire logic break_b,
  input wire logic brake_req,
  output logic safety_input_a,
  output logic safety_input_b,
  output logic cpu_brake_open_request
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    safety_input_a = 1'b0;
    safety_input_b = 1'b0;
    cpu_brake_open_request = 1'b0;
  end
  // one chain feeds both inputs; break_x is a broken wire
  always @(negedge ref_clk) begin
    safety_input_a <= chain_closed & ~break_a;
    safety_input_b <= chain_closed & ~break_b;
    cpu_brake_open_request <= brake_req;
  end
endmodule : sbcm_chain_model
`default_nettype wire

// ===== safe_brake_channel_monitor_test.sv
// safe_brake_channel_monitor_test.sv: self-checking bench
`default_nettype none
module safe_brake_channel_monitor_test import sbcm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic chain = 1'b0;
  logic brk_a = 1'b0;
  logic brk_b = 1'b0;
  logic req = 1'b0;
  logic in_fail = 1'b0;
  logic out_fail = 1'b0;
  logic sa, sb, cmd, pa, pb, fb, lk;
  sbcm_state_t st;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  sbcm_chain_model i_sbcm_chain_model (.ref_clk(ref_clk),
    .chain_closed(chain), .break_a(brk_a), .break_b(brk_b),
    .brake_req(req), .safety_input_a(sa), .safety_input_b(sb),
    .cpu_brake_open_request(cmd));
  sbcm_top #(.DISC_CYC(20)) i_sbcm_top (.ref_clk(ref_clk), .rst(rst),
    .safety_input_a(sa), .safety_input_b(sb),
    .cpu_brake_open_request(cmd), .input_fail_det(in_fail),
    .output_fail_det(out_fail), .brake_power_out_a(pa),
    .brake_power_out_b(pb), .safety_feedback_out(fb),
    .locked_open(lk), .mon_state(st));
  always #2 ref_clk = ~ref_clk;
  // ****************************************
  // expectation and checking
  // ****************************************
  function automatic logic [5:0] expect_outs(logic a, logic b, logic c,
      logic inf, logic outf, logic lck);
    logic on;
    logic f;
    logic [1:0] s;
    on = a & b & c;
    f = ~inf & ~lck & ((outf & ~a & ~b) | on);
    s = lck ? SBCM_LOCKED : (a & b) ? SBCM_RELEASED :
      (a ^ b) ? SBCM_HALF : SBCM_SAFE;
    return {on, on, f, lck, s};
  endfunction : expect_outs
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task automatic step(logic c, logic fa, logic fbk, logic rq, logic inf,
      logic outf, int n, logic lck);
    logic [5:0] exp;
    logic [5:0] got;
    chain <= c;
    brk_a <= fa;
    brk_b <= fbk;
    req <= rq;
    in_fail <= inf;
    out_fail <= outf;
    repeat (n) @(negedge ref_clk);
    exp = expect_outs(c & ~fa, c & ~fbk, rq, inf, outf, lck);
    got = {pa, pb, fb, lk, st};
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : step
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      report_and_stop();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(96));
    repeat (5) @(negedge ref_clk);
    rst <= 1'b0;
    step(0, 0, 0, 0, 0, 0, 1, 0);
    step(1, 0, 0, 0, 0, 0, 8, 0);
    step(1, 0, 0, 1, 0, 0, 8, 0);
    step(0, 0, 0, 1, 0, 0, 6, 0);
    step(0, 0, 0, 0, 0, 1, 8, 0);
    step(1, 0, 0, 1, 1, 0, 8, 0);
    step(1, 0, 1, 0, 0, 0, 15, 0);
    step(0, 0, 0, 0, 0, 0, 4, 0);
    step(1, 1, 0, 1, 0, 0, 15, 0);
    step(1, 0, 1, 1, 0, 0, 30, 1);
    step(1, 0, 0, 1, 0, 0, 8, 1);
    step(1, 1, 0, 1, 0, 0, 8, 1);
    step(0, 0, 0, 0, 0, 0, 8, 0);
    repeat (40) begin
      step(1'($urandom % 2),
        ($urandom % 4) == 0, ($urandom % 4) == 0, 1'($urandom % 2),
        ($urandom % 8) == 0, ($urandom % 8) == 0, 8, 0);
      step(0, 0, 0, 0, 0, 0, 6, 0);
    end
    report_and_stop();
  end
endmodule : safe_brake_channel_monitor_test
`default_nettype wire
